/* logic/ltoc_pkg.sv */
package ltoc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	// register offsets (byte addresses on the bus)
	localparam logic [ADDR_W-1:0] OFF_LOOP_ENABLE = 8'h56;
	localparam logic [ADDR_W-1:0] OFF_PORT_SELECT = 8'h57;
	localparam logic [ADDR_W-1:0] OFF_POWER_CTRL = 8'h63;
	localparam logic [ADDR_W-1:0] OFF_PATGEN_CTRL = 8'h64;
	localparam logic [ADDR_W-1:0] OFF_SINGLE_SELECT = 8'h52;
	// field positions
	localparam int BIT_DRIVE_ENABLE = 3;
	localparam int BIT_PICK_WIDE_HI = 2;
	localparam int BIT_PICK_WIDE_LO = 1;
	localparam int BIT_TX_POWERDOWN = 0;
	localparam int BIT_PICK_SINGLE = 7;
	// field codes
	localparam logic [1:0] PICK_PORT_ZERO = 2'h1;
	localparam logic [1:0] PICK_PORT_ONE = 2'h2;
	// reset values
	localparam logic [DATA_W-1:0] RST_LOOP_ENABLE = 8'h00;
	localparam logic [DATA_W-1:0] RST_PORT_SELECT = 8'h00;
	localparam logic [DATA_W-1:0] RST_POWER_CTRL = 8'h00;
	localparam logic [DATA_W-1:0] RST_PATGEN_CTRL = 8'h10;
	localparam logic [DATA_W-1:0] RST_SINGLE_SELECT = 8'h00;
	// writable bit masks
	localparam logic [DATA_W-1:0] MASK_LOOP_ENABLE = 8'h08;
	localparam logic [DATA_W-1:0] MASK_PORT_SELECT = 8'h06;
	localparam logic [DATA_W-1:0] MASK_POWER_CTRL = 8'h01;
	localparam logic [DATA_W-1:0] MASK_PATGEN_CTRL = 8'hff;
	localparam logic [DATA_W-1:0] MASK_SINGLE_SELECT = 8'h80;
endpackage

/* logic/ltoc_loop_through_output_control.sv */
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
// Operation
// (RULE_01) drive enable bit 3 turns loop driver on; 0 at reset keeps it off
// (RULE_02) wide select 01 routes port zero, 10 routes port one
// (RULE_03) software must set drive enable for data to appear on the output
// (RULE_04) software keeps wide and single port selects naming the same port
// (RULE_05) power control bit 0 powers loop transmitter down; reset keeps it up
// (RULE_06) software powers transmitter down before enabling the pattern generator
// (RULE_07) pattern generator control resets to 0x10
// (RULE_08) single select bit 7: 0 picks port zero, 1 picks port one
// (RULE_09) wide select 00 or 11 drives no recovered data
module ltoc_loop_through_output_control (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [31:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_rx_port_zero,
	input wire logic i_rx_port_one,
	output logic o_loop_through_out,
	output logic o_loop_drive_enable,
	output logic o_loop_tx_powerdown,
	output logic o_ports_mismatch,
	output logic [7:0] o_pattern_gen_ctrl
);
	logic [7:0] loop_enable;
	logic [7:0] port_select;
	logic [7:0] power_ctrl;
	logic [7:0] patgen_ctrl;
	logic [7:0] single_select;
	logic [1:0] sync_zero;
	logic [1:0] sync_one;
	logic [1:0] pick_wide;
	logic pick_single;
	logic req;
	logic wr;
	logic [7:0] wbyte;
	logic [7:0] next_rdata;
	logic next_out;

	// a new request is only taken when ack is low, so each access gets one ack
	assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	// writes land on the acknowledging edge, while the master still holds its request
	assign wr = i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_sel[0]
		&& i_wb_adr[31:8] == 24'h00_0000;
	assign wbyte = i_wb_dat[7:0];
	assign pick_wide = port_select[ltoc_pkg::BIT_PICK_WIDE_HI:ltoc_pkg::BIT_PICK_WIDE_LO];
	assign pick_single = single_select[ltoc_pkg::BIT_PICK_SINGLE];

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= req;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			loop_enable <= ltoc_pkg::RST_LOOP_ENABLE;
			port_select <= ltoc_pkg::RST_PORT_SELECT;
			power_ctrl <= ltoc_pkg::RST_POWER_CTRL;
			patgen_ctrl <= ltoc_pkg::RST_PATGEN_CTRL; // RULE_07
			single_select <= ltoc_pkg::RST_SINGLE_SELECT;
		end else if (wr) begin
			// reserved bits are masked off so they always read zero
			if (i_wb_adr[7:0] == ltoc_pkg::OFF_LOOP_ENABLE) begin
				loop_enable <= wbyte & ltoc_pkg::MASK_LOOP_ENABLE;
			end else if (i_wb_adr[7:0] == ltoc_pkg::OFF_PORT_SELECT) begin
				port_select <= wbyte & ltoc_pkg::MASK_PORT_SELECT;
			end else if (i_wb_adr[7:0] == ltoc_pkg::OFF_POWER_CTRL) begin
				power_ctrl <= wbyte & ltoc_pkg::MASK_POWER_CTRL;
			end else if (i_wb_adr[7:0] == ltoc_pkg::OFF_PATGEN_CTRL) begin
				patgen_ctrl <= wbyte & ltoc_pkg::MASK_PATGEN_CTRL;
			end else if (i_wb_adr[7:0] == ltoc_pkg::OFF_SINGLE_SELECT) begin
				single_select <= wbyte & ltoc_pkg::MASK_SINGLE_SELECT;
			end
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		if (i_wb_adr[31:8] != 24'h00_0000) begin
			next_rdata = 8'h00;
		end else if (i_wb_adr[7:0] == ltoc_pkg::OFF_LOOP_ENABLE) begin
			next_rdata = loop_enable;
		end else if (i_wb_adr[7:0] == ltoc_pkg::OFF_PORT_SELECT) begin
			next_rdata = port_select;
		end else if (i_wb_adr[7:0] == ltoc_pkg::OFF_POWER_CTRL) begin
			next_rdata = power_ctrl;
		end else if (i_wb_adr[7:0] == ltoc_pkg::OFF_PATGEN_CTRL) begin
			next_rdata = patgen_ctrl;
		end else if (i_wb_adr[7:0] == ltoc_pkg::OFF_SINGLE_SELECT) begin
			next_rdata = single_select;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_wb_dat <= 32'h0000_0000;
		end else if (req && !i_wb_we) begin
			o_wb_dat <= {24'h00_0000, next_rdata};
		end
	end

	// recovered data arrives from another domain, so two flops before use
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync_zero <= 2'h0;
			sync_one <= 2'h0;
		end else begin
			sync_zero <= {sync_zero[0], i_rx_port_zero};
			sync_one <= {sync_one[0], i_rx_port_one};
		end
	end

	// the wide select steers the mux; the single select only flags a mismatch
	always_comb begin
		next_out = 1'b0; // RULE_09
		if (pick_wide == ltoc_pkg::PICK_PORT_ZERO) begin
			next_out = sync_zero[1]; // RULE_02
		end else if (pick_wide == ltoc_pkg::PICK_PORT_ONE) begin
			next_out = sync_one[1]; // RULE_02
		end
		// without the driver enable or with the transmitter down, output idles low
		if (!loop_enable[ltoc_pkg::BIT_DRIVE_ENABLE]
			|| power_ctrl[ltoc_pkg::BIT_TX_POWERDOWN]) begin
			next_out = 1'b0; // RULE_01 RULE_05
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_loop_through_out <= 1'b0;
			o_loop_drive_enable <= 1'b0;
			o_loop_tx_powerdown <= 1'b0;
			o_ports_mismatch <= 1'b0;
			o_pattern_gen_ctrl <= ltoc_pkg::RST_PATGEN_CTRL;
		end else begin
			o_loop_through_out <= next_out;
			o_loop_drive_enable <= loop_enable[ltoc_pkg::BIT_DRIVE_ENABLE]; // RULE_01
			o_loop_tx_powerdown <= power_ctrl[ltoc_pkg::BIT_TX_POWERDOWN]; // RULE_05
			// RULE_08
			o_ports_mismatch <= (pick_wide == ltoc_pkg::PICK_PORT_ZERO && pick_single)
				|| (pick_wide == ltoc_pkg::PICK_PORT_ONE && !pick_single);
			o_pattern_gen_ctrl <= patgen_ctrl;
		end
	end

	// qualifiers shared by the checks below
	logic route_live;
	logic rd_take;
	assign route_live = loop_enable[ltoc_pkg::BIT_DRIVE_ENABLE]
		&& !power_ctrl[ltoc_pkg::BIT_TX_POWERDOWN];
	assign rd_take = req && !i_wb_we && i_wb_adr[31:8] == 24'h00_0000;

	sequence s_take;
		req;
	endsequence

	sequence s_answer;
		o_wb_ack ##1 !o_wb_ack;
	endsequence

	sequence s_rx_port_zero_live;
		pick_wide == ltoc_pkg::PICK_PORT_ZERO && route_live;
	endsequence

	sequence s_rx_port_one_live;
		pick_wide == ltoc_pkg::PICK_PORT_ONE && route_live;
	endsequence

	// codes 00 and 11 name no port, so the output must stay quiet
	sequence s_no_port;
		pick_wide != ltoc_pkg::PICK_PORT_ZERO && pick_wide != ltoc_pkg::PICK_PORT_ONE;
	endsequence

	a_drive_follows: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_01
		o_loop_drive_enable == $past(loop_enable[ltoc_pkg::BIT_DRIVE_ENABLE]))
		else $error("drive enable does not follow its bit");

	a_power_follows: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_05
		o_loop_tx_powerdown == $past(power_ctrl[ltoc_pkg::BIT_TX_POWERDOWN]))
		else $error("powerdown does not follow its bit");

	a_rx_port_zero_route: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_02
		s_rx_port_zero_live |=> o_loop_through_out == $past(sync_zero[1]))
		else $error("port zero not routed");

	a_rx_port_one_route: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_02
		s_rx_port_one_live |=> o_loop_through_out == $past(sync_one[1]))
		else $error("port one not routed");

	a_none_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_09
		s_no_port |=> !o_loop_through_out)
		else $error("output active with no port selected");

	a_driver_off_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_01
		!loop_enable[ltoc_pkg::BIT_DRIVE_ENABLE] |=> !o_loop_through_out)
		else $error("output active with driver off");

	a_tx_down_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_05
		power_ctrl[ltoc_pkg::BIT_TX_POWERDOWN] |=> !o_loop_through_out)
		else $error("output active with transmitter down");

	a_mismatch_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_08
		(pick_wide == ltoc_pkg::PICK_PORT_ZERO && !pick_single) |=> !o_ports_mismatch)
		else $error("false mismatch on port zero");

	a_mismatch_agree: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_08
		(pick_wide == ltoc_pkg::PICK_PORT_ONE && pick_single) |=> !o_ports_mismatch)
		else $error("false mismatch on port one");

	a_mismatch_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_08
		(pick_wide == ltoc_pkg::PICK_PORT_ZERO && pick_single) |=> o_ports_mismatch)
		else $error("mismatch missed with wide select on port zero");

	a_mismatch_one: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_08
		(pick_wide == ltoc_pkg::PICK_PORT_ONE && !pick_single) |=> o_ports_mismatch)
		else $error("mismatch missed with wide select on port one");

	a_patgen_reset: assert property (@(posedge i_ref_clk) // RULE_07
		$rose(i_rst_b) |-> patgen_ctrl == ltoc_pkg::RST_PATGEN_CTRL)
		else $error("pattern control reset value wrong");

	a_patgen_copy: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_07
		o_pattern_gen_ctrl == $past(patgen_ctrl))
		else $error("pattern control output does not follow its register");

	a_ack_once: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_wb_ack |=> !o_wb_ack)
		else $error("ack held two cycles");

	a_ack_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		s_take |=> s_answer)
		else $error("taken request not answered by a single ack");

	a_ack_needs_take: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		!req |=> !o_wb_ack)
		else $error("ack without a request");

	a_write_enable_reg: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_01
		(wr && i_wb_adr[7:0] == ltoc_pkg::OFF_LOOP_ENABLE) |=>
		loop_enable == ($past(wbyte) & ltoc_pkg::MASK_LOOP_ENABLE))
		else $error("enable register write lost");

	a_write_select_reg: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_02
		(wr && i_wb_adr[7:0] == ltoc_pkg::OFF_PORT_SELECT) |=>
		port_select == ($past(wbyte) & ltoc_pkg::MASK_PORT_SELECT))
		else $error("port select write lost");

	a_write_power_reg: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_05
		(wr && i_wb_adr[7:0] == ltoc_pkg::OFF_POWER_CTRL) |=>
		power_ctrl == ($past(wbyte) & ltoc_pkg::MASK_POWER_CTRL))
		else $error("power control write lost");

	a_write_patgen_reg: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_07
		(wr && i_wb_adr[7:0] == ltoc_pkg::OFF_PATGEN_CTRL) |=>
		patgen_ctrl == ($past(wbyte) & ltoc_pkg::MASK_PATGEN_CTRL))
		else $error("pattern control write lost");

	a_write_single_reg: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_08
		(wr && i_wb_adr[7:0] == ltoc_pkg::OFF_SINGLE_SELECT) |=>
		single_select == ($past(wbyte) & ltoc_pkg::MASK_SINGLE_SELECT))
		else $error("single select write lost");

	a_read_enable_reg: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_01
		(rd_take && i_wb_adr[7:0] == ltoc_pkg::OFF_LOOP_ENABLE) |=>
		o_wb_dat[7:0] == $past(loop_enable))
		else $error("enable register read wrong");

	a_read_select_reg: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_02
		(rd_take && i_wb_adr[7:0] == ltoc_pkg::OFF_PORT_SELECT) |=>
		o_wb_dat[7:0] == $past(port_select))
		else $error("port select read wrong");

	a_read_patgen_reg: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RULE_07
		(rd_take && i_wb_adr[7:0] == ltoc_pkg::OFF_PATGEN_CTRL) |=>
		o_wb_dat[7:0] == $past(patgen_ctrl))
		else $error("pattern control read wrong");

	a_read_high_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_wb_dat[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");

	// reserved bits must never hold a one, whatever software wrote
	a_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		(loop_enable & ~ltoc_pkg::MASK_LOOP_ENABLE) == 8'h00
		&& (port_select & ~ltoc_pkg::MASK_PORT_SELECT) == 8'h00
		&& (power_ctrl & ~ltoc_pkg::MASK_POWER_CTRL) == 8'h00
		&& (single_select & ~ltoc_pkg::MASK_SINGLE_SELECT) == 8'h00)
		else $error("reserved register bit set");
endmodule

/* verification/ltoc_loop_through_output_control_tb.sv */
`timescale 1ns/1ps
module ltoc_loop_through_output_control_tb;
	logic clk = 0;
	logic rst_b = 0;
	logic cyc = 0;
	logic stb = 0;
	logic we = 0;
	logic rz = 0;
	logic ro = 0;
	logic [31:0] adr = 0;
	logic [31:0] wdat = 0;
	logic [3:0] sel = 0;
	logic [31:0] rdat;
	logic ack, lo, de, pd, mm;
	logic [7:0] pg;
	int err_count = 0;
	int checks_done = 0;
	logic [31:0] seed = 32'h0000_0c5c;
	logic [7:0] mreg [0:255];
	logic [7:0] at [0:5] = '{8'h56, 8'h57, 8'h63, 8'h64, 8'h52, 8'h30};
	ltoc_loop_through_output_control u_dut (.i_ref_clk(clk), .i_rst_b(rst_b),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
		.i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .i_rx_port_zero(rz),
		.i_rx_port_one(ro), .o_loop_through_out(lo), .o_loop_drive_enable(de),
		.o_loop_tx_powerdown(pd), .o_ports_mismatch(mm), .o_pattern_gen_ctrl(pg));
	initial forever #2 clk = ~clk;
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// only documented field bits are writable; unmapped places read zero
	function logic [7:0] msk(logic [7:0] a);
		case (a)
			8'h56: return 8'h08;
			8'h57: return 8'h06;
			8'h63: return 8'h01;
			8'h64: return 8'hff;
			8'h52: return 8'h80;
			default: return 8'h00;
		endcase
	endfunction
	task final_report();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(string n, logic [31:0] s, logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task wb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s, output logic [31:0] r);
		int i;
		i = 0;
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= {24'h00_0000, a};
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 50);
		if (i >= 50) begin
			err_count++;
			final_report();
		end else begin
			r = rdat;
			cyc <= 0;
			stb <= 0;
			we <= 0;
			if (w && s[0])
				mreg[a] = d[7:0] & msk(a);
		end
	endtask
	task outs();
		logic [1:0] wd;
		logic ex;
		wd = mreg[8'h57][2:1];
		ex = (wd == 2'h1 && mreg[8'h52][7]) || (wd == 2'h2 && !mreg[8'h52][7]);
		chk("drive_enable", de, mreg[8'h56][3]);
		chk("tx_powerdown", pd, mreg[8'h63][0]);
		chk("pattern_gen_ctrl", pg, mreg[8'h64]);
		chk("mismatch", mm, ex);
	endtask
	initial begin
		logic [31:0] r;
		logic [7:0] a;
		int i, k;
		foreach (mreg[j]) mreg[j] = 8'h00;
		mreg[8'h64] = 8'h10;
		repeat (4) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
		outs();
		for (i = 0; i < 6; i++) begin
			wb(0, at[i], 0, 4'hf, r);
			chk("reset_read", r, {24'h00_0000, mreg[at[i]]});
		end
		$display("reset values test done");
		for (i = 0; i < 60; i++) begin
			a = at[rnd() % 6];
			wb(1, a, rnd(), rnd() & 32'h0000_000f, r);
			wb(0, a, 0, 4'hf, r);
			chk("readback", r, {24'h00_0000, mreg[a]});
			outs();
		end
		$display("random register test done");
		rst_b <= 0;
		repeat (2) @(posedge clk);
		rst_b <= 1;
		foreach (mreg[j]) mreg[j] = 8'h00;
		mreg[8'h64] = 8'h10;
		@(posedge clk);
		outs();
		wb(0, 8'h64, 0, 4'hf, r);
		chk("reset_again_read", r, {24'h00_0000, mreg[8'h64]});
		$display("mid-run reset test done");
		wb(1, 8'h56, 32'h0000_0008, 4'h1, r);
		wb(1, 8'h63, 32'h0000_0000, 4'h1, r);
		for (k = 0; k < 5; k++) begin
			// last pass powers the transmitter down while wide select 11 from the previous pass already keeps the output quiet
			if (k == 4) begin
				wb(1, 8'h63, 32'h0000_0001, 4'h1, r);
				// pattern generator only once the transmitter is down
				wb(1, 8'h64, 32'h0000_0011, 4'h1, r);
			end
			wb(1, 8'h52, k == 2 ? 32'h0000_0080 : 32'h0000_0000, 4'h1, r);
			wb(1, 8'h57, (k % 4) << 1, 4'h1, r);
			for (i = 0; i < 8; i++) begin
				rz <= 1'(rnd());
				ro <= 1'(rnd());
				repeat (4) @(posedge clk);
				chk("loop_out", lo, k == 4 ? 0 : k == 1 ? rz : k == 2 ? ro : 0);
			end
			outs();
		end
		outs();
		$display("routing test done");
		final_report();
	end
endmodule
